// [src/mcu_cfg.svh]
`ifndef MCU_CFG_SVH
`define MCU_CFG_SVH
`define MCU_ADDR_W           16
`define MCU_DATA_W           16
`define MCU_ADDR_ALARM_HI    16'h0180
`define MCU_ADDR_ALARM_LO    16'h0181
`define MCU_ADDR_ABSERR_HI   16'h0182
`define MCU_ADDR_ABSERR_LO   16'h0183
`define MCU_ADDR_AHIST_HI    16'h0184
`define MCU_ADDR_AHIST_LO    16'h0185
`define MCU_ADDR_WHIST_HI    16'h0186
`define MCU_ADDR_WHIST_LO    16'h0187
`define MCU_ADDR_CHIST_HI    16'h0188
`define MCU_ADDR_CHIST_LO    16'h0189
`define MCU_ADDR_PRESET_HI   16'h018A
`define MCU_ADDR_PRESET_LO   16'h018B
`define MCU_ADDR_RECONF_HI   16'h018C
`define MCU_ADDR_RECONF_LO   16'h018D
`define MCU_ADDR_DEFAULT_HI  16'h018E
`define MCU_ADDR_DEFAULT_LO  16'h018F
`define MCU_ADDR_LOAD_HI     16'h0190
`define MCU_ADDR_LOAD_LO     16'h0191
`define MCU_ADDR_STORE_HI    16'h0192
`define MCU_ADDR_STORE_LO    16'h0193
`define MCU_ADDR_BASE        16'h0180
`define MCU_NUM_CMD          10
`define MCU_CMD_W            4
`define MCU_VAL_ZERO         32'h0000_0000
`define MCU_VAL_ONE          32'h0000_0001
`endif

// [src/mcu_pkg.sv]
package mcu_pkg;
   `include "mcu_cfg.svh"
   typedef enum logic [3:0] {
      MCU_CMD_ALARM_RESET,
      MCU_CMD_ABS_ERR_RESET,
      MCU_CMD_ALARM_HIST,
      MCU_CMD_WARN_HIST,
      MCU_CMD_COMM_HIST,
      MCU_CMD_PRESET,
      MCU_CMD_RECONF,
      MCU_CMD_DEFAULTS,
      MCU_CMD_LOAD,
      MCU_CMD_STORE
   } mcu_cmd_type;
   typedef enum logic [1:0] {
      MCU_ST_IDLE,
      MCU_ST_CONFIG
   } mcu_state_type;
endpackage

// [src/mcu_top.sv]
`timescale 1ns/10ps
`include "mcu_cfg.svh"
module mcu_top (
   // clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   // register write port
   input  wire logic                     reg_wr,
   input  wire logic [`MCU_ADDR_W-1:0]   reg_addr,
   input  wire logic [`MCU_DATA_W-1:0]   reg_wdata,
   // driver condition
   input  wire logic                     alarm_active,
   input  wire logic                     motor_running,
   input  wire logic                     tool_busy,
   input  wire logic                     cfg_done,
   input  wire logic                     drv_excite,
   input  wire logic                     drv_brake_hold,
   input  wire logic                     drv_fault,
   input  wire logic                     drv_inputs_ok,
   input  wire logic                     auto_return_req,
   // command pulses and keep_comm_settings level
   output logic                          alarm_reset_pulse,
   output logic                          abs_err_reset_pulse,
   output logic                          alarm_hist_clear_pulse,
   output logic                          warn_hist_clear_pulse,
   output logic                          comm_hist_clear_pulse,
   output logic                          pos_preset_pulse,
   output logic                          recalc_start_pulse,
   output logic                          defaults_pulse,
   output logic                          keep_comm_settings,
   output logic                          bulk_load_pulse,
   output logic                          bulk_store_pulse,
   // driver control
   output logic                          config_busy,
   output logic                          excite_en,
   output logic                          brake_hold,
   output logic                          power_indicator,
   output logic                          fault_indicator,
   output logic                          inputs_accept,
   output logic                          monitor_valid,
   output logic                          auto_return_go
);
   import mcu_pkg::*;

   logic [`MCU_DATA_W-1:0]  hi_q [`MCU_NUM_CMD];
   logic [`MCU_DATA_W-1:0]  lo_q [`MCU_NUM_CMD];
   logic [`MCU_NUM_CMD-1:0] hi_seen_q;
   logic [`MCU_NUM_CMD-1:0] fire_d;
   logic [`MCU_NUM_CMD-1:0] sel_hit;
   logic                    sel_lo;
   logic [`MCU_ADDR_W-1:0]  rel;
   mcu_state_type           state_q;
   logic                    cfg_block_q;
   logic                    go_config;

   assign rel = reg_addr - `MCU_ADDR_BASE;
   assign sel_lo = rel[0];

   // address decode; word index is rel/2
   always_comb begin
      sel_hit = '0;
      if (reg_wr && reg_addr >= `MCU_ADDR_ALARM_HI && reg_addr <= `MCU_ADDR_STORE_LO) begin
         sel_hit[rel[`MCU_CMD_W:1]] = 1'b1;
      end
   end

   // halves stored; edge on 32-bit value when lower half written
   always_comb begin
      fire_d = '0;
      for (int i = 0; i < `MCU_NUM_CMD; i++) begin
         if (sel_hit[i] && sel_lo && hi_seen_q[i] && {hi_q[i], lo_q[i]} == `MCU_VAL_ZERO
             && {hi_q[i], reg_wdata} == `MCU_VAL_ONE) begin
            fire_d[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `MCU_NUM_CMD; i++) begin
            hi_q[i] <= '0;
            lo_q[i] <= '0;
         end
         hi_seen_q <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < `MCU_NUM_CMD; i++) begin
            if (sel_hit[i] && !sel_lo) begin
               hi_q[i]      <= reg_wdata;
               hi_seen_q[i] <= 1'b1;
            end
            if (sel_hit[i] && sel_lo) begin
               lo_q[i] <= reg_wdata;
            end
         end
      end
   end

   // command pulses and keep_comm_settings level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alarm_reset_pulse      <= 1'b0;
         abs_err_reset_pulse    <= 1'b0;
         alarm_hist_clear_pulse <= 1'b0;
         warn_hist_clear_pulse  <= 1'b0;
         comm_hist_clear_pulse  <= 1'b0;
         pos_preset_pulse       <= 1'b0;
         defaults_pulse         <= 1'b0;
         bulk_load_pulse        <= 1'b0;
         bulk_store_pulse       <= 1'b0;
         keep_comm_settings     <= 1'b1;
      end else if (clk_en) begin
         alarm_reset_pulse      <= fire_d[MCU_CMD_ALARM_RESET];
         abs_err_reset_pulse    <= fire_d[MCU_CMD_ABS_ERR_RESET];
         alarm_hist_clear_pulse <= fire_d[MCU_CMD_ALARM_HIST];
         warn_hist_clear_pulse  <= fire_d[MCU_CMD_WARN_HIST];
         comm_hist_clear_pulse  <= fire_d[MCU_CMD_COMM_HIST];
         pos_preset_pulse       <= fire_d[MCU_CMD_PRESET];
         defaults_pulse         <= fire_d[MCU_CMD_DEFAULTS];
         keep_comm_settings     <= 1'b1;
         bulk_load_pulse        <= fire_d[MCU_CMD_LOAD];
         bulk_store_pulse       <= fire_d[MCU_CMD_STORE];
      end
   end

   assign go_config = fire_d[MCU_CMD_RECONF] && !alarm_active && !motor_running
                      && !tool_busy;

   // configuration sequence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q            <= MCU_ST_IDLE;
         recalc_start_pulse <= 1'b0;
         cfg_block_q        <= 1'b0;
      end else if (clk_en) begin
         recalc_start_pulse <= 1'b0;
         unique case (state_q)
            MCU_ST_IDLE: begin
               if (go_config) begin
                  state_q            <= MCU_ST_CONFIG;
                  recalc_start_pulse <= 1'b1;
               end
               if (!auto_return_req) begin
                  cfg_block_q <= 1'b0;
               end
            end
            MCU_ST_CONFIG: begin
               if (cfg_done) begin
                  state_q     <= MCU_ST_IDLE;
                  cfg_block_q <= 1'b1;
               end
            end
            default: state_q <= MCU_ST_IDLE;
         endcase
      end
   end

   // driver outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         config_busy     <= 1'b0;
         excite_en       <= 1'b0;
         brake_hold      <= 1'b1;
         power_indicator <= 1'b1;
         fault_indicator <= 1'b0;
         inputs_accept   <= 1'b0;
         monitor_valid   <= 1'b0;
         auto_return_go  <= 1'b0;
      end else if (clk_en) begin
         if (state_q == MCU_ST_CONFIG) begin
            config_busy     <= 1'b1;
            excite_en       <= 1'b0;
            brake_hold      <= 1'b1;
            power_indicator <= 1'b1;
            fault_indicator <= 1'b0;
            inputs_accept   <= 1'b0;
            monitor_valid   <= 1'b0;
            auto_return_go  <= 1'b0;
         end else begin
            config_busy     <= 1'b0;
            excite_en       <= drv_excite;
            brake_hold      <= drv_brake_hold;
            power_indicator <= 1'b1;
            fault_indicator <= drv_fault;
            inputs_accept   <= drv_inputs_ok;
            monitor_valid   <= 1'b1;
            auto_return_go  <= auto_return_req && !cfg_block_q;
         end
      end
   end
endmodule

// [verification/mcu_chk_sva.sv]
`timescale 1ns/10ps
`include "mcu_cfg.svh"
module mcu_chk (
   // clock, reset, inputs
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire logic                   reg_wr,
   input wire logic [`MCU_ADDR_W-1:0] reg_addr,
   input wire logic [`MCU_DATA_W-1:0] reg_wdata,
   input wire logic                   alarm_active,
   input wire logic                   motor_running,
   input wire logic                   tool_busy,
   input wire logic                   cfg_done,
   // outputs
   input wire logic                   alarm_reset_pulse,
   input wire logic                   recalc_start_pulse,
   input wire logic                   keep_comm_settings,
   input wire logic                   config_busy,
   input wire logic                   excite_en,
   input wire logic                   brake_hold,
   input wire logic                   power_indicator,
   input wire logic                   fault_indicator,
   input wire logic                   inputs_accept,
   input wire logic                   auto_return_go
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_fire; alarm_reset_pulse |-> $past(reg_wr && reg_addr == `MCU_ADDR_ALARM_LO && reg_wdata == 16'h0001); endproperty
   a_fire: assert property (p_fire) else $error("alarm reset without trigger write");
   property p_hi; reg_wr && !reg_addr[0] |=> !alarm_reset_pulse && !recalc_start_pulse; endproperty
   a_hi: assert property (p_hi) else $error("upper write fired a command");
   property p_cond; recalc_start_pulse |-> $past(!alarm_active && !motor_running && !tool_busy); endproperty
   a_cond: assert property (p_cond) else $error("configuration started while blocked");
   property p_start; recalc_start_pulse |=> config_busy; endproperty
   a_start: assert property (p_start) else $error("configuration not entered");
   property p_run; config_busy |-> !excite_en && brake_hold && power_indicator && !fault_indicator && !inputs_accept; endproperty
   a_run: assert property (p_run) else $error("driver state wrong in configuration");
   property p_done; config_busy && cfg_done |-> ##[1:2] !config_busy; endproperty
   a_done: assert property (p_done) else $error("configuration did not end");
   property p_ret; $fell(config_busy) |-> !auto_return_go [*2]; endproperty
   a_ret: assert property (p_ret) else $error("automatic return right after configuration");
   property p_keep; keep_comm_settings; endproperty
   a_keep: assert property (p_keep) else $error("comm settings not kept");
endmodule
bind mcu_top mcu_chk i_mcu_chk (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .alarm_active,
   .motor_running, .tool_busy, .cfg_done, .alarm_reset_pulse, .recalc_start_pulse,
   .keep_comm_settings, .config_busy, .excite_en, .brake_hold, .power_indicator,
   .fault_indicator, .inputs_accept, .auto_return_go);

// [verification/mcu_drv_model.sv]
`timescale 1ns/10ps
module mcu_drv_model #(
   parameter int DELAY = 20
) (
   // clock, reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // configuration handshake
   input  wire logic start,
   output logic      done
);
   int cnt_q;
   // ends a configuration DELAY cycles after its start
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 0;
         done  <= 1'b0;
      end else begin
         done  <= (cnt_q == 1);
         if (start) begin
            cnt_q <= DELAY;
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
`include "mcu_cfg.svh"
module testbench;
   logic        clk, sys_rst, clk_en, reg_wr, alarm_active, motor_running, tool_busy, cfg_done;
   logic        drv_excite, drv_brake_hold, drv_fault, drv_inputs_ok, auto_return_req, clr;
   logic [15:0] reg_addr, reg_wdata;
   logic        alarm_reset_pulse, abs_err_reset_pulse, alarm_hist_clear_pulse, defaults_pulse;
   logic        warn_hist_clear_pulse, comm_hist_clear_pulse, pos_preset_pulse, excite_en;
   logic        recalc_start_pulse, keep_comm_settings, bulk_load_pulse, bulk_store_pulse;
   logic        config_busy, brake_hold, power_indicator, fault_indicator, inputs_accept;
   logic        monitor_valid, auto_return_go;
   logic [9:0]  seen_q;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   mcu_top i_mcu_top (.*);
   mcu_drv_model #(.DELAY(20)) i_mcu_drv_model (.clk, .sys_rst, .start(recalc_start_pulse),
      .done(cfg_done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // collects command pulses between clears
   always @(posedge clk) begin
      seen_q <= clr ? 10'h000 : seen_q | {bulk_store_pulse, bulk_load_pulse, defaults_pulse,
         recalc_start_pulse, pos_preset_pulse, comm_hist_clear_pulse, warn_hist_clear_pulse,
         alarm_hist_clear_pulse, abs_err_reset_pulse, alarm_reset_pulse};
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   // clears the pulse record, then writes upper and lower half of command i
   task automatic fire(input int i, input logic [15:0] hi, input logic [15:0] lo);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wr(`MCU_ADDR_BASE + 16'(2 * i), hi);
      wr(`MCU_ADDR_BASE + 16'(2 * i + 1), lo);
      repeat (3) @(posedge clk);
   endtask
   initial begin
      {sys_rst, clk_en, clr, drv_excite, drv_inputs_ok, auto_return_req} = 6'h3F;
      {reg_wr, alarm_active, motor_running, tool_busy, drv_brake_hold, drv_fault} = 6'h00;
      {reg_addr, reg_wdata} = 32'h0000_0000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         if (i != 6) begin
            fire(i, 16'h0000, 16'h0000);
            fire(i, 16'h0000, 16'h0001);
            chk(16'(seen_q), 16'(1 << i));
         end
      end
      fire(0, 16'h0000, 16'h0001);
      chk(16'(seen_q), 16'h0000);
      clk_en <= 1'b0;
      fire(0, 16'h0000, 16'h0000);
      clk_en <= 1'b1;
      fire(0, 16'h0000, 16'h0001);
      chk(16'(seen_q), 16'h0000);
      chk(16'(keep_comm_settings), 16'h0001);
      fire(5, 16'h0001, 16'h0000);
      fire(5, 16'h0001, 16'h0001);
      chk(16'(seen_q), 16'h0000);
      wr(16'h0194, 16'h0001);
      wr(16'h017F, 16'h0001);
      chk(16'(seen_q), 16'h0000);
      for (int k = 0; k < 3; k++) begin
         {alarm_active, motor_running, tool_busy} <= 3'b100 >> k;
         fire(6, 16'h0000, 16'h0000);
         fire(6, 16'h0000, 16'h0001);
         chk({seen_q, 5'h00, config_busy}, 16'h0000);
      end
      {alarm_active, motor_running, tool_busy} <= 3'b000;
      fire(6, 16'h0000, 16'h0000);
      fire(6, 16'h0000, 16'h0001);
      chk(16'(seen_q), 16'h0040);
      chk({excite_en, brake_hold, power_indicator, fault_indicator, inputs_accept,
         monitor_valid}, 16'h0018);
      for (int n = 0; n < 100 && config_busy !== 1'b0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({config_busy, auto_return_go}, 16'h0000);
      chk({excite_en, brake_hold, fault_indicator, inputs_accept}, 16'h0009);
      auto_return_req <= 1'b0;
      repeat (3) @(posedge clk);
      auto_return_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk(16'(auto_return_go), 16'h0001);
      test_done();
   end
endmodule
